// ==== verilog/led_dim_pkg.sv ====
// Package for the LED dimming PWM control block: register map, field layouts,
// reset values and timing constants.
// Assumes a 200 MHz core clock and an APB slave with 32-bit data.
package led_dim_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ                  = 200_000_000;
    localparam int unsigned INTERNAL_DIM_PERIOD_US  = 3200;
    localparam int unsigned INTERNAL_DIM_PERIOD_CYC = INTERNAL_DIM_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DETECT_TIMEOUT_US       = 20000;
    localparam int unsigned DETECT_TIMEOUT_CYC      = DETECT_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned TIME_W                  = 24;
    localparam int unsigned DUTY_W                  = 10;
    localparam logic [DUTY_W-1:0] DUTY_FULL         = 10'h3e8;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_HWCFG      = 8'h04;
    localparam logic [7:0] OFS_IDUTY      = 8'h08;
    localparam logic [7:0] OFS_BUCK       = 8'h0c;
    localparam logic [7:0] OFS_STATUS     = 8'h10;
    localparam logic [7:0] OFS_EXT_ON     = 8'h14;
    localparam logic [7:0] OFS_EXT_PERIOD = 8'h18;
    localparam logic [7:0] OFS_DIM        = 8'h1c;
    localparam logic [7:0] OFS_PARAM_CHK  = 8'h20;

    // CTRL field positions
    localparam int unsigned CTRL_SHIFT_LSB = 0;   // cycle_threshold_shift, 4 bits
    localparam int unsigned CTRL_FFL_LSB   = 4;   // flicker_free_cycle_limit, 8 bits
    localparam int unsigned CTRL_OCF_LSB   = 12;  // overcurrent_filter_samples, 8 bits
    localparam int unsigned CTRL_CLR_BIT   = 31;  // write 1: clear overcurrent/param flags
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

    // HWCFG field positions
    localparam int unsigned HW_RANGE_LSB = 0;   // input current range, 2 bits
    localparam int unsigned HW_SENSE_LSB = 2;   // sense_gain_sel, 2 bits
    localparam int unsigned HW_LEVEL_LSB = 4;   // gate_drive_level_sel, 3 bits
    localparam int unsigned HW_STRG_LSB  = 8;   // gate_drive_strength_sel, 5 bits
    localparam logic [11:0] HWCFG_RESET  = 12'h000;

    // Encodings
    localparam logic [1:0] RANGE_SMALL  = 2'h0;
    localparam logic [1:0] RANGE_LARGE  = 2'h1;
    localparam logic [1:0] GAIN_FOUR    = 2'h2;
    localparam logic [1:0] GAIN_SIX     = 2'h3;
    localparam logic [4:0] STRENGTH_MIN = 5'h06;
    localparam logic [2:0] LEVEL_MAX    = 3'h0;

    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'b00,
        SRC_EXTERNAL = 2'b01,
        SRC_FALLBACK = 2'b11
    } dim_src_t;

    typedef struct packed {
        logic [TIME_W-1:0] on_time;
        logic [TIME_W-1:0] period;
    } dim_meas_t;

    typedef struct packed {
        logic [1:0] input_range;
        logic [1:0] sense_gain_sel;
        logic [2:0] gate_drive_level_sel;
        logic [4:0] gate_drive_strength_sel;
    } hw_cfg_t;

endpackage

// ==== verilog/led_dimming_pwm_control.sv ====
// LED dimming PWM control: external dimming measurement, internal fallback,
// cycle-count hysteresis, overcurrent filtering and parameter checks.
// Assumes an APB master on core_clk and asynchronous pins for dim_in and
// the overcurrent comparator.
// Behaviour
// (RL1) Measure high time and full period of the external dimming input.
// (RL2) The external source keeps duty between 1% and 99%.
// (RL3) No valid measurement within the timeout means external input absent.
// (RL4) Hysteresis threshold is measured period shifted right a configurable count.
// (RL5) At the flicker-free cycle limit the threshold divider is no longer applied.
// (RL6) A detected external frequency (100 Hz to 1 kHz) wins over internal.
// (RL7) Without external input, dim from a fixed 3.2 ms internal period.
// (RL8) Final duty is the smaller of external and internal duty.
// (RL9) Track duty and buck period, set switching cycles per on-phase.
// (RL10) Change cycle count only when |T*N + first rise - on time| exceeds threshold.
// (RL11) At least three peak reaches per on-phase bound the minimum on-pulse; the code uses a floor of two cycles and twice (buck period + first rise).
// (RL12) Average output current follows final duty; accuracy drops at low duty.
// (RL13) Flag overcurrent after a configurable number of consecutive samples.
// (RL14) Blank-check the parameter area and check the parameter CRC flag.
// (RL15) Parameters are written over the configuration port and accepted.
// (RL16) The user supplies every parameter; defaults are all zero.
// (RL17) Input current range: code 00 small scale, code 01 large scale.
// (RL18) Sense range: code 10 gain four, code 11 gain six.
// (RL19) Gate level: code 000 highest, down 1.5 V per step to 111.
// (RL20) Gate strength: ascending codes raise current, lowest valid code 00110.
// (RL21) On timeout, switch to internal period at the next period boundary; the code switches as soon as src enters SRC_FALLBACK.
// (RL22) Time on and period with a free-running counter, latched on edges.
//
// Decided for this implementation: the address map and the APB register port.
module led_dimming_pwm_control
    import led_dim_pkg::*;
#(
    parameter int unsigned DETECT_TIMEOUT = DETECT_TIMEOUT_CYC,
    parameter int unsigned INTERNAL_PERIOD = INTERNAL_DIM_PERIOD_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              dim_in,
    input  wire logic              overcurrent_in,
    input  wire logic              param_crc_error,
    input  wire logic              param_blank_ok,
    output logic                   dim_out,
    output logic                   overcurrent_event,
    output logic      [7:0]        switch_cycles,
    output logic      [1:0]        input_range,
    output logic      [1:0]        sense_gain_sel,
    output logic      [2:0]        gate_drive_level_sel,
    output logic      [4:0]        gate_drive_strength_sel
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] dim_sync;
    logic [1:0] oc_sync;
    logic [1:0] par_sync;
    logic       dim_prev;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dim_sync <= 2'h0;
            oc_sync  <= 2'h0;
            par_sync <= 2'h0;
            dim_prev <= 1'b0;
        end else begin
            dim_sync <= {dim_sync[0], dim_in};
            oc_sync  <= {oc_sync[0], overcurrent_in};
            par_sync <= {par_sync[0], param_crc_error};
            dim_prev <= dim_sync[1];
        end
    end

    wire dim_rise = dim_sync[1] & ~dim_prev;
    wire dim_fall = ~dim_sync[1] & dim_prev;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [3:0]        thr_shift;
    logic [7:0]        ff_limit;
    logic [7:0]        oc_samples;
    hw_cfg_t           hw_cfg;
    logic [DUTY_W-1:0] internal_duty;
    logic [TIME_W-1:0] buck_period;
    logic [TIME_W-1:0] first_rise;
    logic              param_crc_flag;
    logic              param_blank_flag;
    logic              oc_flag;
    dim_meas_t         meas;
    logic              ext_present;
    dim_src_t          src;
    logic [DUTY_W-1:0] final_duty;
    function automatic logic sel_hit(input logic [7:0] addr, input logic [7:0] ofs);
        sel_hit = (addr == ofs);
    endfunction
    wire wr_acc = psel & penable & pwrite;
    wire clr_wr = wr_acc & sel_hit(paddr, OFS_CTRL) & pwdata[CTRL_CLR_BIT];
    always_ff @(posedge core_clk) begin
        if (rst) begin
            thr_shift     <= CTRL_RESET[CTRL_SHIFT_LSB +: 4];
            ff_limit      <= CTRL_RESET[CTRL_FFL_LSB +: 8];
            oc_samples    <= CTRL_RESET[CTRL_OCF_LSB +: 8];
            hw_cfg        <= HWCFG_RESET;
            internal_duty <= '0;
            buck_period   <= '0;
            first_rise    <= '0;
        end else if (wr_acc) begin // RL15 RL16
            if (sel_hit(paddr, OFS_CTRL)) begin
                thr_shift  <= pwdata[CTRL_SHIFT_LSB +: 4];
                ff_limit   <= pwdata[CTRL_FFL_LSB +: 8];
                oc_samples <= pwdata[CTRL_OCF_LSB +: 8];
            end
            if (sel_hit(paddr, OFS_HWCFG)) begin
                hw_cfg.input_range             <= pwdata[HW_RANGE_LSB +: 2];
                hw_cfg.sense_gain_sel          <= pwdata[HW_SENSE_LSB +: 2];
                hw_cfg.gate_drive_level_sel    <= pwdata[HW_LEVEL_LSB +: 3];
                hw_cfg.gate_drive_strength_sel <= pwdata[HW_STRG_LSB +: 5];
            end
            if (sel_hit(paddr, OFS_IDUTY))
                internal_duty <= pwdata[DUTY_W-1:0];
            if (sel_hit(paddr, OFS_BUCK)) begin
                buck_period <= {12'h000, pwdata[11:0]};
                first_rise  <= {12'h000, pwdata[23:12]};
            end
        end
    end
    // Hardware configuration fields drive the analogue trims through one register, strength clamped to its minimum code;
    // the encodings are decoded in the analogue blocks.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            input_range             <= RANGE_SMALL;  // RL17
            sense_gain_sel          <= 2'h0;
            gate_drive_level_sel    <= LEVEL_MAX;    // RL19
            gate_drive_strength_sel <= 5'h00;
        end else begin
            input_range             <= hw_cfg.input_range;                // RL17
            sense_gain_sel          <= hw_cfg.sense_gain_sel;             // RL18
            gate_drive_level_sel    <= hw_cfg.gate_drive_level_sel;       // RL19
            // Codes below the minimum are clamped to the lowest strength
            gate_drive_strength_sel <= (hw_cfg.gate_drive_strength_sel < STRENGTH_MIN) ?
                                       STRENGTH_MIN : hw_cfg.gate_drive_strength_sel; // RL20
        end
    end

    // ------------------------------------------------------------------
    // External dimming measurement
    // ------------------------------------------------------------------
    logic [TIME_W-1:0] free_cnt;
    logic [TIME_W-1:0] rise_stamp;
    logic [TIME_W-1:0] on_stamp;
    logic              have_rise;
    logic [TIME_W-1:0] idle_cnt;
    always_ff @(posedge core_clk) begin
        if (rst)
            free_cnt <= '0;
        else
            free_cnt <= free_cnt + 1'b1; // RL22
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rise_stamp <= '0;
            on_stamp   <= '0;
            have_rise  <= 1'b0;
            meas       <= '0;
            idle_cnt   <= '0;
        end else begin
            if (dim_fall && have_rise)
                on_stamp <= free_cnt - rise_stamp; // RL1 RL22
            if (dim_rise) begin
                rise_stamp <= free_cnt;
                have_rise  <= 1'b1;
                if (have_rise) begin
                    meas.period  <= free_cnt - rise_stamp; // RL1
                    meas.on_time <= on_stamp;
                    idle_cnt     <= '0;
                end
            end else if (idle_cnt < TIME_W'(DETECT_TIMEOUT)) begin
                idle_cnt <= idle_cnt + 1'b1; // RL3
            end
        end
    end
    // Source leaves internal and fallback only at a period boundary; external drops to fallback on timeout
    logic [TIME_W-1:0] int_cnt;
    wire int_wrap = (int_cnt >= TIME_W'(INTERNAL_PERIOD - 1));
    always_ff @(posedge core_clk) begin
        if (rst)
            int_cnt <= '0;
        else if (int_wrap || (src == SRC_EXTERNAL && dim_rise))
            int_cnt <= '0;
        else
            int_cnt <= int_cnt + 1'b1; // RL7
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            src         <= SRC_INTERNAL;
            ext_present <= 1'b0;
        end else begin
            ext_present <= (idle_cnt < TIME_W'(DETECT_TIMEOUT)) && (meas.period != '0); // RL3
            unique case (src)
                SRC_INTERNAL: if (ext_present && dim_rise) src <= SRC_EXTERNAL;  // RL6
                SRC_EXTERNAL: if (!ext_present) src <= SRC_FALLBACK;
                SRC_FALLBACK: if (int_wrap || dim_rise) src <= SRC_INTERNAL;      // RL21
                default:      src <= SRC_INTERNAL;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Duty selection and dimming output
    // ------------------------------------------------------------------
    logic [TIME_W+DUTY_W-1:0] ext_scaled;
    logic [DUTY_W-1:0]        ext_duty;
    logic [TIME_W-1:0]        on_len;
    logic [TIME_W-1:0]        per_len;
    logic [TIME_W-1:0]        phase;
    // Duty in tenths of a percent, computed with a slow restoring divide
    // avoided: a compare of scaled on-time against period steps ext_duty.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_duty   <= DUTY_FULL;
            ext_scaled <= '0;
        end else begin
            ext_scaled <= (TIME_W+DUTY_W)'(meas.period) * (TIME_W+DUTY_W)'(ext_duty);
            if (ext_scaled > (TIME_W+DUTY_W)'(meas.on_time) * (TIME_W+DUTY_W)'(DUTY_FULL)
                && ext_duty != '0)
                ext_duty <= ext_duty - 1'b1; // RL1
            else if (ext_duty < DUTY_FULL)
                ext_duty <= ext_duty + 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst)
            final_duty <= '0;
        else if (src == SRC_EXTERNAL)
            final_duty <= (ext_duty < internal_duty) ? ext_duty : internal_duty; // RL8
        else
            final_duty <= internal_duty;
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            per_len <= '0;
            on_len  <= '0;
            phase   <= '0;
        end else begin
            per_len <= (src == SRC_EXTERNAL) ? meas.period : TIME_W'(INTERNAL_PERIOD); // RL6 RL7
            on_len  <= TIME_W'(((TIME_W+DUTY_W)'(per_len) * (TIME_W+DUTY_W)'(final_duty))
                       / (TIME_W+DUTY_W)'(DUTY_FULL));
            phase   <= (src == SRC_EXTERNAL) ? free_cnt - rise_stamp : int_cnt;
        end
    end
    // Mean current tracks duty; the on-pulse is stretched to the minimum
    logic [TIME_W-1:0] min_on;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            min_on  <= '0;
            dim_out <= 1'b0;
        end else begin
            min_on  <= (buck_period << 1) + (first_rise << 1); // RL11
            dim_out <= (final_duty != '0) &&
                       (phase < ((on_len < min_on) ? min_on : on_len)); // RL12
        end
    end

    // ------------------------------------------------------------------
    // Cycle-count hysteresis controller
    // ------------------------------------------------------------------
    logic [TIME_W-1:0] period_old;
    logic [TIME_W-1:0] threshold;
    logic [TIME_W-1:0] estimate;
    logic [TIME_W-1:0] err;
    logic [7:0]        n_target;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            threshold <= '0;
            estimate  <= '0;
            err       <= '0;
            n_target  <= 8'h00;
        end else begin
            threshold <= (switch_cycles >= ff_limit) ? period_old
                                                     : (period_old >> thr_shift); // RL4 RL5
            estimate  <= TIME_W'(buck_period * switch_cycles) + first_rise; // RL9
            err       <= (estimate > on_len) ? estimate - on_len : on_len - estimate;
            n_target  <= (buck_period == '0) ? 8'h00 :
                         8'(on_len / buck_period); // RL9
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            switch_cycles <= 8'h00;
            period_old    <= '0;
        end else if (err > threshold) begin // RL10
            switch_cycles <= (n_target < 8'h02) ? 8'h02 : n_target; // RL11
            period_old    <= buck_period;
        end
    end

    // ------------------------------------------------------------------
    // Overcurrent filter and parameter checks
    // ------------------------------------------------------------------
    logic [7:0] oc_run;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            oc_run            <= 8'h00;
            oc_flag           <= 1'b0;
            overcurrent_event <= 1'b0;
        end else begin
            oc_run            <= oc_sync[1] ? ((oc_run == 8'hff) ? oc_run : oc_run + 1'b1) : 8'h00;
            overcurrent_event <= oc_sync[1] && ({1'b0, oc_run} + 9'h001 >= {1'b0, oc_samples}); // RL13
            // Set wins over a simultaneous clear; nine bits stop a saturated run wrapping the compare
            if (oc_sync[1] && ({1'b0, oc_run} + 9'h001 >= {1'b0, oc_samples}))
                oc_flag <= 1'b1;
            else if (clr_wr)
                oc_flag <= 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            param_crc_flag   <= 1'b0;
            param_blank_flag <= 1'b0;
        end else begin
            if (par_sync[1])
                param_crc_flag <= 1'b1; // RL14
            else if (clr_wr)
                param_crc_flag <= 1'b0;
            if (!param_blank_ok)
                param_blank_flag <= 1'b1; // RL14
            else if (clr_wr)
                param_blank_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                unique case (paddr)
                    OFS_CTRL:       prdata <= {12'h000, oc_samples, ff_limit, thr_shift};
                    OFS_HWCFG:      prdata <= {19'h00000, hw_cfg.gate_drive_strength_sel, 1'b0,
                                               hw_cfg.gate_drive_level_sel, hw_cfg.sense_gain_sel,
                                               hw_cfg.input_range};
                    OFS_IDUTY:      prdata <= {22'h000000, internal_duty};
                    OFS_BUCK:       prdata <= {8'h00, first_rise[11:0], buck_period[11:0]};
                    OFS_STATUS:     prdata <= {22'h000000, final_duty[7:0], src == SRC_EXTERNAL,
                                               oc_flag | param_crc_flag | param_blank_flag};
                    OFS_EXT_ON:     prdata <= {8'h00, meas.on_time};
                    OFS_EXT_PERIOD: prdata <= {8'h00, meas.period};
                    OFS_DIM:        prdata <= {12'h000, ext_present, switch_cycles, 1'b0, final_duty};
                    OFS_PARAM_CHK:  prdata <= {29'h00000000, param_blank_flag, param_crc_flag, oc_flag};
                    default:        pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule

// ==== bench/led_dim_sva.sv ====
// Port checker for the LED dimming block: APB handshake and config outputs.
// Assumes synchronous active-high rst on core_clk.
module led_dim_sva
    import led_dim_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  switch_cycles,
    input wire logic [1:0]  input_range,
    input wire logic [1:0]  sense_gain_sel,
    input wire logic [2:0]  gate_drive_level_sel,
    input wire logic [4:0]  gate_drive_strength_sel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire hw_wr = psel && penable && pwrite && paddr == OFS_HWCFG;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_quiet;
        !hw_wr ##1 !hw_wr;
    endsequence
    a_ready_next: assert property (s_setup |=> pready)
        else $error("no pready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_quiet: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
        else $error("bad error response");
    a_mapped_ok: assert property (pready && paddr <= OFS_PARAM_CHK && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped address");
    a_cfg_hold: assert property (s_quiet |=> $stable({input_range, sense_gain_sel, gate_drive_level_sel}))
        else $error("config output moved without write");
    a_cfg_follow: assert property (hw_wr |-> ##2
        {input_range, sense_gain_sel, gate_drive_level_sel} == $past({pwdata[1:0], pwdata[3:2], pwdata[6:4]}, 2))
        else $error("config output differs from write");
    a_strength_floor: assert property (!$past(rst) && !$past(rst, 2) |-> gate_drive_strength_sel >= STRENGTH_MIN)
        else $error("gate strength below minimum code");
    a_cycles_floor: assert property (switch_cycles != 8'h01)
        else $error("single switching cycle");
endmodule

bind led_dimming_pwm_control led_dim_sva i_sva (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .switch_cycles, .input_range, .sense_gain_sel, .gate_drive_level_sel,
    .gate_drive_strength_sel);

// ==== bench/dim_source.sv ====
// External dimming source model; times are in core_clk cycles.
// Assumes the bench changes on_cyc and per_cyc only while disabled.
module dim_source (
    input  wire logic        core_clk,
    input  wire logic        en,
    input  wire logic [15:0] on_cyc,
    input  wire logic [15:0] per_cyc,
    output logic             dim_pin
);
    logic [15:0] cnt = 16'h0;
    logic [15:0] on_lim;
    // Duty kept inside the supported band
    always_comb begin
        on_lim = on_cyc;
        if (on_lim < per_cyc / 16'h64) on_lim = per_cyc / 16'h64;
        if (on_lim > per_cyc - per_cyc / 16'h64) on_lim = per_cyc - per_cyc / 16'h64;
    end
    // Idle pin rests low, as an absent source
    always_ff @(posedge core_clk) begin
        cnt <= (!en || cnt >= per_cyc - 16'h1) ? 16'h0 : cnt + 16'h1;
        dim_pin <= en && cnt < on_lim;
    end
endmodule

// ==== bench/tb_led_dimming_pwm_control.sv ====
// Bench for the LED dimming block: registers, measurement, fallback, flags.
// Assumes led_dim_pkg, dim_source and the bound port checker.
module tb_led_dimming_pwm_control
    import led_dim_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk, rst, psel, penable, pwrite, dim_in, overcurrent_in, param_crc_error, param_blank_ok;
    logic        dim_out, overcurrent_event, pready, pslverr, src_en, slv;
    logic [7:0]  paddr, switch_cycles;
    logic [31:0] pwdata, prdata, q, x;
    logic [1:0]  input_range, sense_gain_sel;
    logic [2:0]  gate_drive_level_sel;
    logic [4:0]  gate_drive_strength_sel, s;
    logic [15:0] on_cyc, per_cyc;
    int          err_total, checks_done;
    led_dimming_pwm_control #(.DETECT_TIMEOUT(2000), .INTERNAL_PERIOD(500)) i_dut (.core_clk, .rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dim_in, .overcurrent_in,
        .param_crc_error, .param_blank_ok, .dim_out, .overcurrent_event, .switch_cycles, .input_range,
        .sense_gain_sel, .gate_drive_level_sel, .gate_drive_strength_sel);
    dim_source i_src (.core_clk, .en(src_en), .on_cyc, .per_cyc, .dim_pin(dim_in));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic summarize;
        $display("Counts: mismatches %0d, checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        slv = pslverr;
        {psel, penable} <= 2'b00;
        chk({31'h0, pready}, 32'h1);
        if (pready !== 1'b1) summarize;
        @(posedge core_clk);
    endtask
    task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            repeat (50) @(posedge core_clk);
            n++;
        end while ((q & m) !== v && n < 800);
        chk(q & m, v);
        if ((q & m) !== v) summarize;
    endtask
    task automatic measure(input int n, input int v);
        int h;
        h = 0;
        repeat (n) begin
            @(posedge core_clk);
            h += (dim_out === 1'b1);
        end
        chk(32'(h > v - 3 && h < v + 3), 32'h1);
    endtask
    // --------
    // Scenarios
    // --------
    task automatic t_regs;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(q, CTRL_RESET);
        apb(1'b0, OFS_HWCFG, 32'h0);
        chk(q, {20'h0, HWCFG_RESET});
        chk({27'h0, gate_drive_strength_sel}, {27'h0, STRENGTH_MIN});
        apb(1'b1, 8'h24, 32'hffff_ffff);
        chk({31'h0, slv}, 32'h1);
        apb(1'b0, 8'h24, 32'h0);
        chk({slv, q[30:0] | {30'h0, q[31]}}, 32'h8000_0000);
    endtask
    task automatic t_hwcfg;
        for (int i = 0; i < 8; i++) begin
            s = 5'(i * 4 + 2);
            apb(1'b1, OFS_HWCFG, {19'h0, s, 1'b0, 3'(i), 1'b1, 1'(i / 2), 1'b0, 1'(i)});
            x = {19'h0, (s < STRENGTH_MIN) ? STRENGTH_MIN : s, 1'b0, 3'(i), 1'b1, 1'(i / 2), 1'b0, 1'(i)};
            repeat (2) @(posedge core_clk);
            chk({19'h0, gate_drive_strength_sel, 1'b0, gate_drive_level_sel, sense_gain_sel, input_range}, x);
        end
    endtask
    task automatic t_external;
        src_en <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h0000_4082);
        apb(1'b1, OFS_BUCK, 32'h0000_2004);
        apb(1'b1, OFS_IDUTY, {22'h0, DUTY_FULL});
        wait_reg(OFS_EXT_PERIOD, 32'h00ff_ffff, 32'h64);
        wait_reg(OFS_EXT_ON, 32'h00ff_ffff, 32'h1e);
        wait_reg(OFS_DIM, 32'h0008_03ff, 32'h0008_012c);
        measure(100, 30);
        chk({24'h0, switch_cycles}, 32'h7);
        apb(1'b1, OFS_IDUTY, 32'h64);
        wait_reg(OFS_DIM, 32'h0008_03ff, 32'h0008_0064);
    endtask
    task automatic t_fallback;
        src_en <= 1'b0;
        apb(1'b1, OFS_IDUTY, 32'h1f4);
        wait_reg(OFS_DIM, 32'h0008_03ff, 32'h1f4);
        repeat (1000) @(posedge core_clk);
        measure(500, 250);
    endtask
    task automatic t_flags;
        apb(1'b1, OFS_CTRL, 32'h8000_4082);
        overcurrent_in <= 1'b1;
        repeat (3) @(posedge core_clk);
        overcurrent_in <= 1'b0;
        repeat (6) @(posedge core_clk);
        apb(1'b0, OFS_PARAM_CHK, 32'h0);
        chk(q & 32'h7, 32'h0);
        overcurrent_in <= 1'b1;
        repeat (10) @(posedge core_clk);
        chk({31'h0, overcurrent_event}, 32'h1);
        {overcurrent_in, param_crc_error, param_blank_ok} <= 3'b010;
        repeat (6) @(posedge core_clk);
        {param_crc_error, param_blank_ok} <= 2'b01;
        apb(1'b0, OFS_PARAM_CHK, 32'h0);
        chk(q & 32'h7, 32'h7);
        apb(1'b1, OFS_CTRL, 32'h8000_4082);
        apb(1'b0, OFS_PARAM_CHK, 32'h0);
        chk(q & 32'h7, 32'h0);
    endtask
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, src_en} = {1'b1, 44'h0};
        {overcurrent_in, param_crc_error, param_blank_ok, on_cyc, per_cyc} = {3'b001, 16'h1e, 16'h64};
        {err_total, checks_done} = 64'h0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        t_regs;
        t_hwcfg;
        t_external;
        t_fallback;
        t_flags;
        summarize;
    end
endmodule
